// ---- hdl/oscr_pkg.sv ----
// Package with register map, field layout, reset values and carriers of the oscillator regs.
package oscr_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 16;
   localparam logic [31:0] FAST_CTRL_OFS = 32'h5000_0024;
   localparam logic [31:0] SLOW_CTRL_OFS = 32'h5000_0026;
   localparam logic [31:0] REF_TRIM_OFS = 32'h5000_0028;
   localparam logic [31:0] ANA_STAT_OFS = 32'h5000_002a;
   localparam logic [31:0] XTAL_TRIM_OFS = 32'h5000_0030;
   localparam logic [31:0] XTAL_RDY_OFS = 32'h5000_0034;
   // Widths of each register, all writable but the status word; the bits above read as zero.
   localparam int FAST_W = 11;
   localparam int SLOW_W = 12;
   localparam int REF_W = 10;
   localparam int XTAL_W = 16;
   localparam int RDY_W = 8;
   localparam int ANA_W = 13;
   // Reset images: fast cap 0xf, range 0, bias 0x7, off 0.
   localparam logic [10:0] FAST_RST = 11'h78e;
   // Slow osc: bias 0xa, unit cap 1, cap adjust 0x1f, res 0, on 0.
   localparam logic [11:0] SLOW_RST = 12'hafc;
   localparam logic [9:0] REF_RST = 10'h000;
   localparam logic [15:0] XTAL_RST = 16'h00aa;
   localparam logic [7:0] RDY_RST = 8'h00;
   // Ramp trim takes over from the start trim after this timeout.
   localparam int CLK_PERIOD_PS = 25000;
   localparam int RAMP_TIMEOUT_US = 32;
   localparam int RAMP_TIMEOUT_CYC = (RAMP_TIMEOUT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TMO_W = 11;

   typedef struct packed {
      logic [3:0] fast_osc_cap_adjust;
      logic [1:0] fast_osc_coarse_range;
      logic [3:0] fast_osc_bias_adjust;
      logic fast_osc_off;
      logic [3:0] slow_osc_regulator_bias;
      logic slow_osc_unit_cap;
      logic [4:0] slow_osc_cap_adjust;
      logic slow_osc_res_select;
      logic slow_osc_on;
      logic [4:0] reference_current_trim;
      logic [4:0] reference_voltage_trim;
   } oscr_ctrl_t;

   // Analog monitor levels, laid out as bits 12:0 of the status word, where spare reads as zero.
   typedef struct packed {
      logic wake_tree_output;
      logic spare;
      logic converter_adc_reg_good;
      logic crystal_reg_good;
      logic boost_detected;
      logic high_rail_ok;
      logic low_rail_ok;
      logic reference_good;
      logic high_below_low;
      logic high_above_low;
      logic switcher_rail_good;
      logic low_reg_good;
      logic core_reg_good;
   } oscr_ana_t;

   typedef enum logic [3:0] {
      TRIM_IDLE = 4'h1,
      TRIM_START = 4'h2,
      TRIM_RAMP = 4'h4,
      TRIM_FINAL = 4'h8
   } oscr_trim_st_t;
endpackage : oscr_pkg

// ---- hdl/oscr_regs.sv ----
// Oscillator trim, reference trim, analog status and crystal-ready counter registers.
//
// What this block does
// - Fast osc cap adjust, 4 bits, reset 0xf.
// - Fast osc coarse range, 2 bits, reset 0.
// - Off bit stops fast osc; sleep stops it.
// - Slow osc regulator bias, 4 bits, reset 0xa.
// - Slow osc unit cap bit, reset one.
// - Slow osc cap adjust, 5 bits, reset 0x1f.
// - Slow osc resistance select, reset zero.
// - Slow osc runs only when enabled, reset off.
// - Reference current and voltage trims, reset zero.
// - Status shows wake tree output.
// - Status shows high and low rail monitors.
// - Status shows reference and regulator good flags.
// - Status shows rail comparator results.
// - Status shows boost detect and converter good.
// - Crystal ramp and start trims, start 0xaa.
// - Count slow clocks after enable, then interrupt.
// - Zero settle count raises no interrupt.
// - Start trim, ramp after 32us, final on amplitude.
`timescale 1ns/100ps
module oscr_regs (
   input wire logic REF_CLK_IN, // 40 MHz register clock
   input wire logic RESET_IN, // Synchronous reset, active high
   input wire logic [31:0] ADDR_IN, // Register address
   input wire logic [15:0] WDATA_IN, // Write data
   input wire logic WR_IN, // Write strobe
   input wire logic RD_IN, // Read strobe
   output logic [15:0] RDATA_OUT, // Read data, cycle after strobe
   input wire oscr_pkg::oscr_ana_t ANA_IN, // Asynchronous analog monitor levels
   input wire logic SLEEP_IN, // System sleep request, asynchronous
   input wire logic CLK32K_IN, // 32 kHz clock, sampled as data
   input wire logic XTAL_EN_IN, // Crystal enable level, asynchronous
   input wire logic XTAL_AMPL_OK_IN, // Crystal amplitude reached, moves trim to final
   input wire logic TWO_STAGE_IN, // Two-stage trim option selected
   input wire logic [7:0] FINAL_TRIM_IN, // Final crystal trim value
   output oscr_pkg::oscr_ctrl_t CTRL_OUT, // Oscillator and reference trims
   output logic FAST_OSC_RUN_OUT, // Fast RC oscillator runs
   output logic [7:0] XTAL_TRIM_OUT, // Trim applied to the crystal
   output logic XTAL_SETTLED_IRQ_OUT // Crystal-ready pulse, one cycle
);
   localparam int SYNC_W = oscr_pkg::ANA_W + 5;

   logic [10:0] fast_q;
   logic [10:0] fast_d;
   logic [11:0] slow_q;
   logic [11:0] slow_d;
   logic [9:0] ref_q;
   logic [9:0] ref_d;
   logic [15:0] xtal_q;
   logic [15:0] xtal_d;
   logic [7:0] rdy_q;
   logic [7:0] rdy_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   oscr_pkg::oscr_ctrl_t ctrl_q;
   oscr_pkg::oscr_ctrl_t ctrl_d;
   logic run_q;
   logic run_d;

   // Register file.
   always_comb begin
      fast_d = fast_q;
      slow_d = slow_q;
      ref_d = ref_q;
      xtal_d = xtal_q;
      rdy_d = rdy_q;
      if (WR_IN) begin
         if (ADDR_IN == oscr_pkg::FAST_CTRL_OFS) begin
            fast_d = WDATA_IN[10:0];
         end else if (ADDR_IN == oscr_pkg::SLOW_CTRL_OFS) begin
            slow_d = WDATA_IN[11:0];
         end else if (ADDR_IN == oscr_pkg::REF_TRIM_OFS) begin
            ref_d = WDATA_IN[9:0];
         end else if (ADDR_IN == oscr_pkg::XTAL_TRIM_OFS) begin
            xtal_d = WDATA_IN;
         end else if (ADDR_IN == oscr_pkg::XTAL_RDY_OFS) begin
            rdy_d = WDATA_IN[7:0];
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         fast_q <= oscr_pkg::FAST_RST;
         slow_q <= oscr_pkg::SLOW_RST;
         ref_q <= oscr_pkg::REF_RST;
         xtal_q <= oscr_pkg::XTAL_RST;
         rdy_q <= oscr_pkg::RDY_RST;
      end else begin
         fast_q <= fast_d;
         slow_q <= slow_d;
         ref_q <= ref_d;
         xtal_q <= xtal_d;
         rdy_q <= rdy_d;
      end
   end

   // Pin synchronisers. The first stage feeds only the second stage.
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [SYNC_W-1:0] sync_pins;
   logic [12:0] ana_s;
   logic sleep_s;
   logic clk32_s;
   logic xen_s;
   logic ampl_s;
   logic two_s;

   assign sync_pins = {ANA_IN, SLEEP_IN, CLK32K_IN, XTAL_EN_IN, XTAL_AMPL_OK_IN, TWO_STAGE_IN};
   assign ana_s = sync2_q[SYNC_W-1:5];
   assign sleep_s = sync2_q[4];
   assign clk32_s = sync2_q[3];
   assign xen_s = sync2_q[2];
   assign ampl_s = sync2_q[1];
   assign two_s = sync2_q[0];

   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= sync_pins;
         sync2_q <= sync1_q;
      end
   end

   // Read path. The status word has no write decode, so writes to it fall away.
   always_comb begin
      rdata_d = 16'h0000;
      if (RD_IN) begin
         if (ADDR_IN == oscr_pkg::FAST_CTRL_OFS) begin
            rdata_d = {5'h00, fast_q};
         end else if (ADDR_IN == oscr_pkg::SLOW_CTRL_OFS) begin
            rdata_d = {4'h0, slow_q};
         end else if (ADDR_IN == oscr_pkg::REF_TRIM_OFS) begin
            rdata_d = {6'h00, ref_q};
         end else if (ADDR_IN == oscr_pkg::ANA_STAT_OFS) begin
            rdata_d = {3'h0, ana_s[12], 1'b0, ana_s[10:0]};
         end else if (ADDR_IN == oscr_pkg::XTAL_TRIM_OFS) begin
            rdata_d = xtal_q;
         end else if (ADDR_IN == oscr_pkg::XTAL_RDY_OFS) begin
            rdata_d = {8'h00, rdy_q};
         end
      end
   end

   // Trim outputs and fast oscillator run control.
   always_comb begin
      ctrl_d.fast_osc_cap_adjust = fast_q[10:7];
      ctrl_d.fast_osc_coarse_range = fast_q[6:5];
      ctrl_d.fast_osc_bias_adjust = fast_q[4:1];
      ctrl_d.fast_osc_off = fast_q[0];
      ctrl_d.slow_osc_regulator_bias = slow_q[11:8];
      ctrl_d.slow_osc_unit_cap = slow_q[7];
      ctrl_d.slow_osc_cap_adjust = slow_q[6:2];
      ctrl_d.slow_osc_res_select = slow_q[1];
      ctrl_d.slow_osc_on = slow_q[0];
      ctrl_d.reference_current_trim = ref_q[9:5];
      ctrl_d.reference_voltage_trim = ref_q[4:0];
      // Sleep drops the oscillator without touching the software bit.
      run_d = ~fast_q[0] & ~sleep_s;
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         rdata_q <= 16'h0000;
         ctrl_q <= '0;
         run_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
         run_q <= run_d;
      end
   end

   assign RDATA_OUT = rdata_q;
   assign CTRL_OUT = ctrl_q;
   assign FAST_OSC_RUN_OUT = run_q;

   // Crystal-ready counter. The 32 kHz clock is sampled, so it counts rising edges
   // seen on the register clock; this costs up to three cycles of latency per edge.
   logic clk32_prev_q;
   logic xen_prev_q;
   logic armed_q;
   logic armed_d;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic irq_q;
   logic irq_d;
   logic slow_edge;
   logic xen_rise;

   assign slow_edge = clk32_s & ~clk32_prev_q;
   assign xen_rise = xen_s & ~xen_prev_q;

   always_comb begin
      armed_d = armed_q;
      cnt_d = cnt_q;
      irq_d = 1'b0;
      if (!xen_s) begin
         armed_d = 1'b0;
      end else if (xen_rise) begin
         cnt_d = 8'h00;
         armed_d = (rdy_q != 8'h00);
      end else if (rdy_q == 8'h00) begin
         armed_d = 1'b0;
      end else if (armed_q && slow_edge) begin
         cnt_d = cnt_q + 8'h01;
         if (cnt_q + 8'h01 == rdy_q) begin
            irq_d = 1'b1;
            armed_d = 1'b0;
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         clk32_prev_q <= 1'b0;
         xen_prev_q <= 1'b0;
         armed_q <= 1'b0;
         cnt_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         clk32_prev_q <= clk32_s;
         xen_prev_q <= xen_s;
         armed_q <= armed_d;
         cnt_q <= cnt_d;
         irq_q <= irq_d;
      end
   end

   assign XTAL_SETTLED_IRQ_OUT = irq_q;

   // Crystal trim sequencing.
   oscr_pkg::oscr_trim_st_t st_q;
   oscr_pkg::oscr_trim_st_t st_d;
   logic [oscr_pkg::TMO_W-1:0] tmo_q;
   logic [oscr_pkg::TMO_W-1:0] tmo_d;
   logic [7:0] trim_q;
   logic [7:0] trim_d;
   localparam logic [oscr_pkg::TMO_W-1:0] TMO_LAST =
      oscr_pkg::TMO_W'(oscr_pkg::RAMP_TIMEOUT_CYC - 1);

   always_comb begin
      st_d = st_q;
      tmo_d = tmo_q;
      case (st_q)
         oscr_pkg::TRIM_IDLE: begin
            tmo_d = '0;
            if (xen_rise) begin
               st_d = oscr_pkg::TRIM_START;
            end
         end
         oscr_pkg::TRIM_START: begin
            tmo_d = tmo_q + 1'b1;
            if (two_s && tmo_q >= TMO_LAST) begin
               st_d = oscr_pkg::TRIM_RAMP;
            end else if (!two_s && ampl_s) begin
               st_d = oscr_pkg::TRIM_FINAL;
            end
         end
         oscr_pkg::TRIM_RAMP: begin
            if (ampl_s) begin
               st_d = oscr_pkg::TRIM_FINAL;
            end
         end
         oscr_pkg::TRIM_FINAL: begin
            st_d = oscr_pkg::TRIM_FINAL;
         end
         default: begin
            st_d = oscr_pkg::TRIM_IDLE;
         end
      endcase
      if (!xen_s) begin
         st_d = oscr_pkg::TRIM_IDLE;
      end
      case (st_d)
         oscr_pkg::TRIM_START: trim_d = xtal_q[7:0];
         oscr_pkg::TRIM_RAMP: trim_d = xtal_q[15:8];
         default: trim_d = FINAL_TRIM_IN;
      endcase
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         st_q <= oscr_pkg::TRIM_IDLE;
         tmo_q <= '0;
         trim_q <= 8'h00;
      end else begin
         st_q <= st_d;
         tmo_q <= tmo_d;
         trim_q <= trim_d;
      end
   end

   assign XTAL_TRIM_OUT = trim_q;

   // Cycles spent in the start phase with two stages selected; only the timeout check reads it.
   logic [11:0] start_cyc_q;
   logic [11:0] start_cyc_d;

   always_comb begin
      start_cyc_d = 12'h000;
      if (st_q == oscr_pkg::TRIM_START && two_s) begin
         start_cyc_d = start_cyc_q + 12'h001;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (RESET_IN) begin
         start_cyc_q <= 12'h000;
      end else begin
         start_cyc_q <= start_cyc_d;
      end
   end

   // Checks.
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (RESET_IN);

   fast_cap_reset_a: assert property ($fell(RESET_IN) |=>
      CTRL_OUT.fast_osc_cap_adjust == 4'hf && CTRL_OUT.fast_osc_coarse_range == 2'h0)
      else $error("fast osc fields wrong after reset");
   fast_run_a: assert property ((fast_q[0] || sleep_s) |=> !FAST_OSC_RUN_OUT)
      else $error("fast osc runs while off or asleep");
   fast_on_a: assert property ((!fast_q[0] && !sleep_s) |=> FAST_OSC_RUN_OUT)
      else $error("fast osc stopped without cause");
   slow_write_a: assert property (WR_IN && ADDR_IN == oscr_pkg::SLOW_CTRL_OFS |=> ##1
      CTRL_OUT.slow_osc_on == $past(WDATA_IN[0], 2)
      && CTRL_OUT.slow_osc_cap_adjust == $past(WDATA_IN[6:2], 2))
      else $error("slow osc fields not taken from write");
   ref_trim_a: assert property (WR_IN && ADDR_IN == oscr_pkg::REF_TRIM_OFS |=> ##1
      CTRL_OUT.reference_current_trim == $past(WDATA_IN[9:5], 2))
      else $error("reference trim not taken from write");
   status_read_a: assert property (RD_IN && ADDR_IN == oscr_pkg::ANA_STAT_OFS |=>
      RDATA_OUT[15:13] == 3'h0 && RDATA_OUT[11] == 1'b0
      && RDATA_OUT[12] == $past(sync2_q[SYNC_W-1]))
      else $error("status word layout wrong");
   reserved_zero_a: assert property (RD_IN && ADDR_IN == oscr_pkg::FAST_CTRL_OFS |=>
      RDATA_OUT[15:11] == 5'h00)
      else $error("reserved bits not zero");
   idle_read_a: assert property (!RD_IN |=> RDATA_OUT == 16'h0000)
      else $error("read data outside read cycle");
   zero_cnt_a: assert property (rdy_q == 8'h00 && $stable(rdy_q) |=>
      !XTAL_SETTLED_IRQ_OUT)
      else $error("interrupt with zero settle count");
   irq_count_a: assert property ($rose(XTAL_SETTLED_IRQ_OUT) |->
      $past(cnt_q) + 8'h01 == rdy_q && xen_s)
      else $error("interrupt before count reached");
   ramp_timeout_a: assert property (st_q == oscr_pkg::TRIM_START && two_s
      |-> start_cyc_q < 12'(oscr_pkg::RAMP_TIMEOUT_CYC))
      else $error("ramp trim not reached after timeout");
   ramp_trim_a: assert property (st_q == oscr_pkg::TRIM_RAMP |->
      XTAL_TRIM_OUT == $past(xtal_q[15:8]))
      else $error("ramp trim not applied");
   irq_pulse_a: assert property (XTAL_SETTLED_IRQ_OUT |=> !XTAL_SETTLED_IRQ_OUT)
      else $error("crystal-ready pulse longer than one cycle");
   start_trim_a: assert property (st_q == oscr_pkg::TRIM_START |->
      XTAL_TRIM_OUT == $past(xtal_q[7:0]))
      else $error("start trim not applied");
   final_trim_a: assert property (st_q == oscr_pkg::TRIM_FINAL |->
      XTAL_TRIM_OUT == $past(FINAL_TRIM_IN))
      else $error("final trim not applied");

   irq_fire_c: cover property (XTAL_SETTLED_IRQ_OUT);
   ramp_seen_c: cover property (st_q == oscr_pkg::TRIM_RAMP ##1 st_q == oscr_pkg::TRIM_FINAL);
   sleep_stop_c: cover property (sleep_s && !fast_q[0] ##1 !FAST_OSC_RUN_OUT);
   status_rd_c: cover property (RD_IN && ADDR_IN == oscr_pkg::ANA_STAT_OFS);
endmodule : oscr_regs

// ---- tb/test_oscr_regs.sv ----
// Self-checking testbench of the oscillator trim and analog status registers.
`timescale 1ns/100ps
module test_oscr_regs;
   logic REF_CLK_IN, RESET_IN, WR_IN, RD_IN, SLEEP_IN, CLK32K_IN;
   logic XTAL_EN_IN, XTAL_AMPL_OK_IN, TWO_STAGE_IN;
   logic [31:0] ADDR_IN;
   logic [15:0] WDATA_IN, RDATA_OUT;
   logic [7:0] FINAL_TRIM_IN, XTAL_TRIM_OUT;
   logic FAST_OSC_RUN_OUT, XTAL_SETTLED_IRQ_OUT;
   oscr_pkg::oscr_ana_t ANA_IN;
   oscr_pkg::oscr_ctrl_t CTRL_OUT;
   int err_total = 0;
   int samples_checked = 0;
   int irq_cnt = 0;
   logic [15:0] m_fast, m_slow, m_ref, m_xtal, m_rdy, r, d;
   logic [31:0] a, seed_v;
   logic [31:0] addr_tab [7] = '{oscr_pkg::FAST_CTRL_OFS, oscr_pkg::SLOW_CTRL_OFS,
      oscr_pkg::REF_TRIM_OFS, oscr_pkg::ANA_STAT_OFS, oscr_pkg::XTAL_TRIM_OFS,
      oscr_pkg::XTAL_RDY_OFS, 32'h5000_002c};

   oscr_regs oscr_regs_inst (.REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN),
      .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
      .ANA_IN(ANA_IN), .SLEEP_IN(SLEEP_IN), .CLK32K_IN(CLK32K_IN), .XTAL_EN_IN(XTAL_EN_IN),
      .XTAL_AMPL_OK_IN(XTAL_AMPL_OK_IN), .TWO_STAGE_IN(TWO_STAGE_IN),
      .FINAL_TRIM_IN(FINAL_TRIM_IN), .CTRL_OUT(CTRL_OUT), .FAST_OSC_RUN_OUT(FAST_OSC_RUN_OUT),
      .XTAL_TRIM_OUT(XTAL_TRIM_OUT), .XTAL_SETTLED_IRQ_OUT(XTAL_SETTLED_IRQ_OUT));

   initial begin
      REF_CLK_IN = 1'b0;
      forever #12.5 REF_CLK_IN = ~REF_CLK_IN;
   end

   always @(posedge REF_CLK_IN) begin
      if (XTAL_SETTLED_IRQ_OUT !== 1'b0) irq_cnt <= irq_cnt + 1;
   end

   task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge REF_CLK_IN);
      #1;
   endtask : wait_cyc

   task automatic wr(input logic [31:0] ad, input logic [15:0] wd);
      @(posedge REF_CLK_IN);
      ADDR_IN <= ad;
      WDATA_IN <= wd;
      WR_IN <= 1'b1;
      @(posedge REF_CLK_IN);
      WR_IN <= 1'b0;
      if (ad == oscr_pkg::FAST_CTRL_OFS) m_fast = wd & 16'h07ff;
      if (ad == oscr_pkg::SLOW_CTRL_OFS) m_slow = wd & 16'h0fff;
      if (ad == oscr_pkg::REF_TRIM_OFS) m_ref = wd & 16'h03ff;
      if (ad == oscr_pkg::XTAL_TRIM_OFS) m_xtal = wd;
      if (ad == oscr_pkg::XTAL_RDY_OFS) m_rdy = wd & 16'h00ff;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rd(input logic [31:0] ad, output logic [15:0] rd_v);
      @(posedge REF_CLK_IN);
      ADDR_IN <= ad;
      RD_IN <= 1'b1;
      @(posedge REF_CLK_IN);
      RD_IN <= 1'b0;
      #1;
      rd_v = RDATA_OUT;
   endtask : rd

   function automatic logic [15:0] exp_rd(input logic [31:0] ad);
      logic [12:0] s;
      s = ANA_IN;
      case (ad)
         oscr_pkg::FAST_CTRL_OFS: exp_rd = m_fast;
         oscr_pkg::SLOW_CTRL_OFS: exp_rd = m_slow;
         oscr_pkg::REF_TRIM_OFS: exp_rd = m_ref;
         oscr_pkg::ANA_STAT_OFS: exp_rd = {3'h0, s[12], 1'b0, s[10:0]};
         oscr_pkg::XTAL_TRIM_OFS: exp_rd = m_xtal;
         oscr_pkg::XTAL_RDY_OFS: exp_rd = m_rdy;
         default: exp_rd = 16'h0000;
      endcase
   endfunction : exp_rd

   function automatic logic [32:0] exp_ctrl();
      exp_ctrl = {m_fast[10:0], m_slow[11:0], m_ref[9:0]};
   endfunction : exp_ctrl

   task automatic tick32k(input int n);
      repeat (n) begin
         @(posedge REF_CLK_IN);
         CLK32K_IN <= 1'b1;
         repeat (8) @(posedge REF_CLK_IN);
         CLK32K_IN <= 1'b0;
         repeat (8) @(posedge REF_CLK_IN);
      end
      #1;
   endtask : tick32k

   // A stuck sequence would otherwise run forever; allow well over the expected length.
   initial begin
      repeat (20000) @(posedge REF_CLK_IN);
      err_total++;
      end_sim();
   end

   initial begin
      {RESET_IN, WR_IN, RD_IN, SLEEP_IN, CLK32K_IN} = 5'h10;
      {XTAL_EN_IN, XTAL_AMPL_OK_IN, TWO_STAGE_IN} = 3'h0;
      ADDR_IN = 32'h0000_0000;
      WDATA_IN = 16'h0000;
      FINAL_TRIM_IN = 8'h00;
      ANA_IN = '0;
      {m_fast, m_slow, m_ref, m_xtal, m_rdy} = {16'h078e, 16'h0afc, 16'h0000, 16'h00aa, 16'h0000};
      seed_v = $urandom(32'h71f1791b);
      repeat (6) @(posedge REF_CLK_IN);
      RESET_IN <= 1'b0;
      wait_cyc(3);
      ANA_IN <= oscr_pkg::oscr_ana_t'($urandom);
      FINAL_TRIM_IN <= 8'($urandom);
      wait_cyc(3);
      for (int i = 0; i < 7; i++) begin
         rd(addr_tab[i], r);
         chk("reset rdata", r, exp_rd(addr_tab[i]));
      end
      chk("reset ctrl", CTRL_OUT, exp_ctrl());
      chk("fast run", FAST_OSC_RUN_OUT, 1'b1);
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         wr(addr_tab[i], 16'hffff);
         rd(addr_tab[i], r);
         chk("ones rdata", r, exp_rd(addr_tab[i]));
      end
      for (int i = 0; i < 40; i++) begin
         a = addr_tab[$urandom_range(6)];
         d = 16'($urandom);
         if ($urandom_range(1) == 1) wr(a, d);
         rd(a, r);
         chk("rand rdata", r, exp_rd(a));
         wait_cyc(1);
         chk("rand ctrl", CTRL_OUT, exp_ctrl());
      end
      $display("test registers done");
      for (int i = 0; i < 12; i++) begin
         @(posedge REF_CLK_IN);
         ANA_IN <= oscr_pkg::oscr_ana_t'($urandom);
         wait_cyc(3);
         rd(oscr_pkg::ANA_STAT_OFS, r);
         chk("status", r, exp_rd(oscr_pkg::ANA_STAT_OFS));
      end
      $display("test status done");
      wr(oscr_pkg::FAST_CTRL_OFS, m_fast | 16'h0001);
      wait_cyc(3);
      chk("fast off", FAST_OSC_RUN_OUT, 1'b0);
      wr(oscr_pkg::FAST_CTRL_OFS, m_fast & 16'h07fe);
      wait_cyc(3);
      chk("fast on", FAST_OSC_RUN_OUT, 1'b1);
      SLEEP_IN <= 1'b1;
      wait_cyc(5);
      chk("fast sleep", FAST_OSC_RUN_OUT, 1'b0);
      SLEEP_IN <= 1'b0;
      wait_cyc(5);
      chk("fast wake", FAST_OSC_RUN_OUT, 1'b1);
      $display("test fast osc done");
      for (int n = 0; n < 4; n++) begin
         d = (n == 0) ? 16'h0000 : 16'($urandom_range(5, 1));
         wr(oscr_pkg::XTAL_RDY_OFS, d);
         XTAL_EN_IN <= 1'b1;
         wait_cyc(5);
         irq_cnt = 0;
         if (d != 0) tick32k(d - 1);
         wait_cyc(2);
         chk("irq early", irq_cnt, 0);
         tick32k(1);
         chk("irq count", irq_cnt, (d != 0) ? 1 : 0);
         tick32k(2);
         chk("irq once", irq_cnt, (d != 0) ? 1 : 0);
         XTAL_EN_IN <= 1'b0;
         wait_cyc(4);
      end
      $display("test crystal ready done");
      wr(oscr_pkg::XTAL_TRIM_OFS, 16'($urandom));
      for (int t = 0; t < 2; t++) begin
         TWO_STAGE_IN <= t[0];
         XTAL_AMPL_OK_IN <= 1'b0;
         wait_cyc(4);
         chk("trim idle", XTAL_TRIM_OUT, FINAL_TRIM_IN);
         XTAL_EN_IN <= 1'b1;
         wait_cyc(6);
         chk("trim start", XTAL_TRIM_OUT, m_xtal[7:0]);
         wait_cyc(1200);
         chk("trim hold", XTAL_TRIM_OUT, m_xtal[7:0]);
         wait_cyc(100);
         chk("trim ramp", XTAL_TRIM_OUT, (t == 1) ? m_xtal[15:8] : m_xtal[7:0]);
         XTAL_AMPL_OK_IN <= 1'b1;
         wait_cyc(6);
         chk("trim final", XTAL_TRIM_OUT, FINAL_TRIM_IN);
         XTAL_EN_IN <= 1'b0;
      end
      $display("test crystal trim done");
      end_sim();
   end
endmodule : test_oscr_regs
